// ===== hdl/ijs_defines.svh
// Register offsets, field positions, reset values and timing figures of the judgement sequencer
`ifndef IJS_DEFINES_SVH
`define IJS_DEFINES_SVH

// Register byte offsets
`define IJS_CTRL_OFS      12'h000
`define IJS_UPPER_OFS     12'h004
`define IJS_LOWER_OFS     12'h008
`define IJS_RISE_OFS      12'h00C
`define IJS_WAIT_OFS      12'h010
`define IJS_TEST_OFS      12'h014
`define IJS_HOLD_OFS      12'h018
`define IJS_STATUS_OFS    12'h01C
`define IJS_IRQ_STAT_OFS  12'h020
`define IJS_IRQ_CLR_OFS   12'h024
`define IJS_IRQ_EN_OFS    12'h028

// Control fields (start and stop are write-only pulses)
`define IJS_CTRL_START    0
`define IJS_CTRL_STOP     1
`define IJS_CTRL_HOLD     2
`define IJS_CTRL_UP_EN    3
`define IJS_CTRL_LO_EN    4

// Status fields
`define IJS_ST_IDLE       0
`define IJS_ST_RUN        1
`define IJS_ST_DONE       2
`define IJS_ST_OUT_ON     3
`define IJS_ST_PASS       4
`define IJS_ST_UPPER      5
`define IJS_ST_LOWER      6
`define IJS_ST_PASS_OUT   7

// Interrupt event fields
`define IJS_EV_PASS       0
`define IJS_EV_UPPER      1
`define IJS_EV_LOWER      2
`define IJS_EV_STOP       3

// Reset values
`define IJS_CTRL_RST      32'h0000_0018
`define IJS_LIMIT_RST     32'h0000_0000
`define IJS_TIME_RST      32'h0000_0000

// Timebase: clock period and judgement tick, both in ns
`define IJS_CLK_NS        4
`define IJS_TICK_NS       1000000

`endif

// ===== hdl/ijs_pkg.sv
// Types shared by the judgement sequencer files
package ijs_pkg;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      IJS_IDLE = 3'b001,
      IJS_RUN  = 3'b010,
      IJS_DONE = 3'b100
   } ijs_state_t;

endpackage : ijs_pkg

// ===== hdl/ijs_tick.sv
// Timebase prescaler: one pulse every TICK_CYCLES clocks while enabled
`timescale 1ns/1ps
`default_nettype none

module ijs_tick #(
   parameter int TICK_CYCLES = 250000
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Control and pulse
   input  wire logic run,
   output logic      tick
);

   generate
      if (TICK_CYCLES < 1) begin : g_bad
         $error("TICK_CYCLES must be at least one");
      end
   endgenerate

   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic        next_tick;

   ////////////////////////////////////////////////////////////////////////
   // Count restarts whenever run drops, so a test's first tick is a full period
   always_comb begin
      next_cnt  = cnt + 32'h0000_0001;
      next_tick = 1'b0;
      if (!run) begin
         next_cnt = 32'h0000_0000;
      end else if (cnt >= 32'(TICK_CYCLES - 1)) begin
         next_cnt  = 32'h0000_0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt  <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end

endmodule : ijs_tick
`default_nettype wire

// ===== hdl/ijs_top.sv
// Insulation judgement sequencer: limits, timing windows, verdict outputs and APB registers
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ijs_defines.svh"

module ijs_top
   import ijs_pkg::*;
#(
   parameter int RES_W       = 32,
   parameter int TIME_W      = 16,
   parameter int TICK_CYCLES = `IJS_TICK_NS / `IJS_CLK_NS
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset,
   // APB slave
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Measurement from the front end, same clock
   input  wire logic [RES_W-1:0]  meas_res,
   input  wire logic              meas_valid,
   // Signal I/O port
   input  wire logic              stop_pin,
   output logic                   test_output_on,
   output logic                   pass_out,
   output logic                   upper_fail_out,
   output logic                   lower_fail_out,
   // Indicators
   output logic                   pass_led,
   output logic                   upper_led,
   output logic                   lower_led,
   // Interrupt
   output logic                   irq
);

   generate
      if (RES_W < 1 || RES_W > 32 || TIME_W < 2 || TIME_W > 32) begin : g_bad
         $error("RES_W must be 1..32 and TIME_W 2..32");
      end
   endgenerate

   // Time reached test, used for every window and the hold count
   function automatic logic reached(input logic [TIME_W-1:0] now,
                                    input logic [TIME_W-1:0] lim);
      reached = (now >= lim);
   endfunction : reached

   ////////////////////////////////////////////////////////////////////////
   // Stop pin synchroniser; first stage feeds only the second
   logic stop_meta;
   logic stop_sync;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         stop_meta <= 1'b0;
         stop_sync <= 1'b0;
      end else begin
         stop_meta <= stop_pin;
         stop_sync <= stop_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic [4:0]        ctrl;
   logic [RES_W-1:0]  upper_lim;
   logic [RES_W-1:0]  lower_lim;
   logic [TIME_W-1:0] rise_time;
   logic [TIME_W-1:0] wait_time;
   logic [TIME_W-1:0] test_time;
   logic [TIME_W-1:0] hold_time;
   logic [3:0]        irq_en;
   logic [4:0]        next_ctrl;
   logic [RES_W-1:0]  next_upper_lim;
   logic [RES_W-1:0]  next_lower_lim;
   logic [TIME_W-1:0] next_rise_time;
   logic [TIME_W-1:0] next_wait_time;
   logic [TIME_W-1:0] next_test_time;
   logic [TIME_W-1:0] next_hold_time;
   logic [3:0]        next_irq_en;
   logic [31:0]       next_prdata;
   logic              next_pslverr;
   logic              wr_acc;
   logic              start_req;
   logic              stop_req;
   logic [3:0]        irq_clr;
   logic              mapped;

   // Writes take effect only in the access phase
   assign wr_acc    = psel && penable && pwrite;
   assign pready    = 1'b1;
   assign start_req = wr_acc && paddr == `IJS_CTRL_OFS && pwdata[`IJS_CTRL_START];
   assign stop_req  = stop_sync ||
                      (wr_acc && paddr == `IJS_CTRL_OFS && pwdata[`IJS_CTRL_STOP]);
   assign irq_clr   = (wr_acc && paddr == `IJS_IRQ_CLR_OFS) ? pwdata[3:0] : 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state
   ijs_state_t        state;
   ijs_state_t        next_state;
   logic [TIME_W-1:0] elapsed;
   logic [TIME_W-1:0] next_elapsed;
   logic [TIME_W-1:0] hold_cnt;
   logic [TIME_W-1:0] next_hold_cnt;
   logic              next_out_on;
   logic              next_pass_out;
   logic              pass_q;
   logic              upper_q;
   logic              lower_q;
   logic              next_pass_q;
   logic              next_upper_q;
   logic              next_lower_q;
   logic              tick;
   logic              tick_hold;
   logic              upper_hit;
   logic              lower_hit;
   logic [3:0]        ev;
   logic [3:0]        irq_stat;
   logic [3:0]        next_irq_stat;

   ////////////////////////////////////////////////////////////////////////
   // Register decode and read mux; read data is captured in the setup phase
   always_comb begin
      next_ctrl      = ctrl;
      next_upper_lim = upper_lim;
      next_lower_lim = lower_lim;
      next_rise_time = rise_time;
      next_wait_time = wait_time;
      next_test_time = test_time;
      next_hold_time = hold_time;
      next_irq_en    = irq_en;
      next_prdata    = prdata;
      next_pslverr   = pslverr;
      mapped         = 1'b1;
      case (paddr)
         `IJS_CTRL_OFS:     next_prdata = {27'h000_0000, ctrl[4:2], 2'b00};
         `IJS_UPPER_OFS:    next_prdata = 32'(upper_lim);
         `IJS_LOWER_OFS:    next_prdata = 32'(lower_lim);
         `IJS_RISE_OFS:     next_prdata = 32'(rise_time);
         `IJS_WAIT_OFS:     next_prdata = 32'(wait_time);
         `IJS_TEST_OFS:     next_prdata = 32'(test_time);
         `IJS_HOLD_OFS:     next_prdata = 32'(hold_time);
         `IJS_STATUS_OFS:   next_prdata = {24'h00_0000, pass_out, lower_q, upper_q, pass_q,
                                           test_output_on, state[2], state[1], state[0]};
         `IJS_IRQ_STAT_OFS: next_prdata = {28'h000_0000, irq_stat};
         `IJS_IRQ_CLR_OFS:  next_prdata = 32'h0000_0000;
         `IJS_IRQ_EN_OFS:   next_prdata = {28'h000_0000, irq_en};
         default: begin
            next_prdata = 32'h0000_0000;
            mapped      = 1'b0;
         end
      endcase
      if (psel && !penable) begin
         next_pslverr = !mapped;
      end else begin
         next_prdata  = prdata;
      end
      // Limits and times are not changed mid-test, so windows stay consistent
      if (wr_acc && mapped && !(state == IJS_RUN && paddr != `IJS_CTRL_OFS)) begin
         case (paddr)
            `IJS_CTRL_OFS:   next_ctrl      = {pwdata[4:2], 2'b00};
            `IJS_UPPER_OFS:  next_upper_lim = pwdata[RES_W-1:0];
            `IJS_LOWER_OFS:  next_lower_lim = pwdata[RES_W-1:0];
            `IJS_RISE_OFS:   next_rise_time = pwdata[TIME_W-1:0];
            `IJS_WAIT_OFS:   next_wait_time = pwdata[TIME_W-1:0];
            `IJS_TEST_OFS:   next_test_time = pwdata[TIME_W-1:0];
            `IJS_HOLD_OFS:   next_hold_time = pwdata[TIME_W-1:0];
            `IJS_IRQ_EN_OFS: next_irq_en    = pwdata[3:0];
            default:         next_ctrl      = ctrl;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl      <= 5'(`IJS_CTRL_RST);
         upper_lim <= RES_W'(`IJS_LIMIT_RST);
         lower_lim <= RES_W'(`IJS_LIMIT_RST);
         rise_time <= TIME_W'(`IJS_TIME_RST);
         wait_time <= TIME_W'(`IJS_TIME_RST);
         test_time <= TIME_W'(`IJS_TIME_RST);
         hold_time <= TIME_W'(`IJS_TIME_RST);
         irq_en    <= 4'h0;
         prdata    <= 32'h0000_0000;
         pslverr   <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         upper_lim <= next_upper_lim;
         lower_lim <= next_lower_lim;
         rise_time <= next_rise_time;
         wait_time <= next_wait_time;
         test_time <= next_test_time;
         hold_time <= next_hold_time;
         irq_en    <= next_irq_en;
         prdata    <= next_prdata;
         pslverr   <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Judgement timebase, restarted at each test start
   ijs_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .core_clk (core_clk),
      .reset    (reset),
      .run      (state == IJS_RUN),
      .tick     (tick)
   );

   // Window gating; an unvalidated sample is never judged
   assign upper_hit = ctrl[`IJS_CTRL_UP_EN] && meas_valid && meas_res > upper_lim &&
                      reached(elapsed, rise_time);
   assign lower_hit = ctrl[`IJS_CTRL_LO_EN] && meas_valid && meas_res < lower_lim &&
                      reached(elapsed, wait_time);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: a fault outranks the pass at the last tick
   always_comb begin
      next_state    = state;
      next_elapsed  = elapsed;
      next_hold_cnt = hold_cnt;
      next_out_on   = test_output_on;
      next_pass_out = pass_out;
      next_pass_q   = pass_q;
      next_upper_q  = upper_q;
      next_lower_q  = lower_q;
      ev            = 4'h0;
      case (state)
         IJS_IDLE: begin
            if (start_req && !stop_req) begin
               next_state   = IJS_RUN;
               next_elapsed = '0;
               next_out_on  = 1'b1;
            end
         end
         IJS_RUN: begin
            if (tick && elapsed != '1) begin
               next_elapsed = elapsed + TIME_W'(1);
            end
            if (stop_req) begin
               next_state  = IJS_IDLE;
               next_out_on = 1'b0;
               ev[`IJS_EV_STOP] = 1'b1;
            end else if (upper_hit) begin
               next_state   = IJS_DONE;
               next_out_on  = 1'b0;
               next_upper_q = 1'b1;
               ev[`IJS_EV_UPPER] = 1'b1;
            end else if (lower_hit) begin
               next_state   = IJS_DONE;
               next_out_on  = 1'b0;
               next_lower_q = 1'b1;
               ev[`IJS_EV_LOWER] = 1'b1;
            end else if (reached(elapsed, test_time)) begin
               next_state    = IJS_DONE;
               next_out_on   = 1'b0;
               next_pass_q   = 1'b1;
               next_pass_out = 1'b1;
               next_hold_cnt = '0;
               ev[`IJS_EV_PASS] = 1'b1;
            end
         end
         IJS_DONE: begin
            if (stop_req) begin
               next_state    = IJS_IDLE;
               next_pass_out = 1'b0;
               next_pass_q   = 1'b0;
               next_upper_q  = 1'b0;
               next_lower_q  = 1'b0;
               ev[`IJS_EV_STOP] = 1'b1;
            end else if (pass_out && !ctrl[`IJS_CTRL_HOLD]) begin
               // Hold time counted in ticks of a second divider that runs only while the pass output is held
               if (reached(hold_cnt, hold_time)) begin
                  next_pass_out = 1'b0;
               end else if (tick_hold) begin
                  next_hold_cnt = hold_cnt + TIME_W'(1);
               end
            end
         end
         default: begin
            next_state = IJS_IDLE;
         end
      endcase
   end

   // Second divider for the hold phase, since the test timebase halts outside a run
   ijs_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_hold_tick (
      .core_clk (core_clk),
      .reset    (reset),
      .run      (state == IJS_DONE && pass_out),
      .tick     (tick_hold)
   );

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state          <= IJS_IDLE;
         elapsed        <= '0;
         hold_cnt       <= '0;
         test_output_on <= 1'b0;
         pass_out       <= 1'b0;
         pass_q         <= 1'b0;
         upper_q        <= 1'b0;
         lower_q        <= 1'b0;
      end else begin
         state          <= next_state;
         elapsed        <= next_elapsed;
         hold_cnt       <= next_hold_cnt;
         test_output_on <= next_out_on;
         pass_out       <= next_pass_out;
         pass_q         <= next_pass_q;
         upper_q        <= next_upper_q;
         lower_q        <= next_lower_q;
      end
   end

   // Fail outputs and indicators share the verdict flops
   assign upper_fail_out = upper_q;
   assign lower_fail_out = lower_q;
   assign upper_led      = upper_q;
   assign lower_led      = lower_q;
   assign pass_led       = pass_q;

   ////////////////////////////////////////////////////////////////////////
   // Sticky events; a new event in the clearing cycle survives
   always_comb begin
      next_irq_stat = (irq_stat & ~irq_clr) | ev;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_stat <= 4'h0;
         irq      <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq      <= |(next_irq_stat & irq_en);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   upper_cut_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(upper_fail_out) |-> !test_output_on && $past(state == IJS_RUN)
         && $past(meas_res > upper_lim))
      else $error("upper fail without cut or without cause");

   rise_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(upper_fail_out) |-> $past(elapsed) >= $past(rise_time))
      else $error("upper fail inside ramp interval");

   lower_cut_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(lower_fail_out) |-> !test_output_on && !upper_fail_out
         && $past(meas_res < lower_lim))
      else $error("lower fail without cut or without cause");

   wait_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(lower_fail_out) |-> $past(elapsed) >= $past(wait_time))
      else $error("lower fail before wait time");

   pass_end_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(pass_led) |-> pass_out && !test_output_on
         && $past(elapsed) >= $past(test_time) && !$past(upper_hit || lower_hit))
      else $error("pass without test time or with fault");

   pass_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      pass_out && ctrl[`IJS_CTRL_HOLD] && !stop_req |=> pass_out)
      else $error("pass output dropped in hold mode");

   fail_keep_a: assert property (@(posedge core_clk) disable iff (reset)
      (upper_fail_out || lower_fail_out) && !stop_req |=>
         $stable(upper_fail_out) && $stable(lower_fail_out))
      else $error("fail output changed without stop");

   stop_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      stop_req && state != IJS_IDLE |=> state == IJS_IDLE && !pass_out
         && !upper_led && !lower_led && !pass_led && !test_output_on)
      else $error("stop did not clear verdicts");

endmodule : ijs_top
`default_nettype wire

// ===== tb/ijs_sio_model.sv
// Model of the equipment on the signal I/O port: answers a verdict with a stop after a delay
`timescale 1ns/1ps
`default_nettype none

module ijs_sio_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Verdict lines seen from the tester
   input  wire logic       pass_out,
   input  wire logic       upper_fail_out,
   input  wire logic       lower_fail_out,
   // Delay before stop, zero leaves stop to software
   input  wire logic [7:0] stop_delay,
   // Stop line back to the tester
   output logic            stop_pin
);
   logic [7:0] wait_cnt;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Hold stop until the verdict lines clear, so a slow tester is never missed
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wait_cnt <= 8'h00;
         stop_pin <= 1'b0;
      end else if (stop_delay != 8'h00 && (pass_out | upper_fail_out | lower_fail_out)) begin
         wait_cnt <= wait_cnt + 8'h01;
         stop_pin <= (wait_cnt >= stop_delay);
      end else begin
         wait_cnt <= 8'h00;
         stop_pin <= 1'b0;
      end
   end
endmodule : ijs_sio_model

`default_nettype wire

// ===== tb/ijs_top_test.sv
// Self-checking testbench of the judgement sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ijs_defines.svh"

module ijs_top_test;
   import ijs_pkg::*;

   logic        core_clk;
   logic        reset;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] meas_res;
   logic        meas_valid;
   logic        stop_pin;
   logic        test_output_on;
   logic        pass_out;
   logic        upper_fail_out;
   logic        lower_fail_out;
   logic        pass_led;
   logic        upper_led;
   logic        lower_led;
   logic        irq;
   logic [7:0]  stop_delay;
   int          failures;
   int          cmp_count;
   int          cycles = 0;
   wire logic [2:0] verd = {lower_fail_out, upper_fail_out, pass_out};
   wire logic [2:0] leds = {lower_led, upper_led, pass_led};

   ////////////////////////////////////////////////////////////////////////////////////////
   // Short tick so that a test of many ticks stays brief
   ijs_top #(.TICK_CYCLES(4)) ijs_top_i (
      .core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas_res(meas_res), .meas_valid(meas_valid), .stop_pin(stop_pin),
      .test_output_on(test_output_on), .pass_out(pass_out), .upper_fail_out(upper_fail_out),
      .lower_fail_out(lower_fail_out), .pass_led(pass_led), .upper_led(upper_led),
      .lower_led(lower_led), .irq(irq));

   ijs_sio_model ijs_sio_model_i (
      .core_clk(core_clk), .reset(reset), .pass_out(pass_out),
      .upper_fail_out(upper_fail_out), .lower_fail_out(lower_fail_out),
      .stop_delay(stop_delay), .stop_pin(stop_pin));

   ////////////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask : wr_reg

   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h0000_0000, rd, er);
      check(name, rd, exp);
   endtask : rd_chk

   // Bounded wait for the verdict lines to reach a pattern
   task automatic wait_for(input logic [2:0] want, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (verd !== want && n < 300);
   endtask : wait_for

   task automatic irq_step(input logic [11:0] a, input logic [31:0] d, input logic exp);
      wr_reg(a, d);
      @(posedge core_clk);
      #1;
      check("irq", irq, exp);
   endtask : irq_step

   // One test: configure, start, judge, hold, stop, then interrupt mask and clear
   task automatic run(input logic [31:0] ctrl, rise, wt, tt, ht, res,
                      input logic [2:0] exp, input int min_cyc, input logic [7:0] dly);
      int   n;
      logic ph;
      ph = (exp == 3'b001) && !ctrl[2];
      wr_reg(`IJS_RISE_OFS, rise);
      wr_reg(`IJS_WAIT_OFS, wt);
      wr_reg(`IJS_TEST_OFS, tt);
      wr_reg(`IJS_HOLD_OFS, ht);
      wr_reg(`IJS_CTRL_OFS, ctrl);
      wr_reg(`IJS_IRQ_CLR_OFS, 32'h0000_000F);
      meas_res   <= res;
      stop_delay <= dly;
      wr_reg(`IJS_CTRL_OFS, ctrl | 32'h0000_0001);
      #1;
      check("output_on_run", test_output_on, 1'b1);
      wait_for(exp, n);
      check("verdict", verd, exp);
      check("leds", leds, exp);
      check("output_on", test_output_on, 1'b0);
      check("judge_delay", n > min_cyc, 1'b1);
      // Timed pass hold is measured first, before bus cycles eat into it
      if (ph) begin
         wait_for(3'b000, n);
         check("pass_hold", n > 2 && n <= 16, 1'b1);
         check("pass_led", pass_led, 1'b1);
      end
      rd_chk("irq_stat", `IJS_IRQ_STAT_OFS, {29'h0000_0000, exp});
      check("irq_on", irq, 1'b1);
      if (!ph) begin
         repeat (8) @(posedge core_clk);
         #1;
         check("verdict_held", verd, exp);
      end
      if (dly == 8'h00)
         wr_reg(`IJS_CTRL_OFS, ctrl | 32'h0000_0002);
      wait_for(3'b000, n);
      repeat (2) @(posedge core_clk);
      #1;
      check("cleared", {verd, leds, test_output_on}, 7'h00);
      rd_chk("status", `IJS_STATUS_OFS, 32'h0000_0001);
      irq_step(`IJS_IRQ_EN_OFS, 32'h0000_0000, 1'b0);
      irq_step(`IJS_IRQ_EN_OFS, 32'h0000_0007, 1'b1);
      irq_step(`IJS_IRQ_CLR_OFS, 32'h0000_000F, 1'b0);
      rd_chk("irq_clear", `IJS_IRQ_STAT_OFS, 32'h0000_0000);
   endtask : run

   ////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] rd;
      logic        er;
      failures   = 0;
      cmp_count  = 0;
      reset      = 1'b1;
      paddr      = 12'h000;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      pwdata     = 32'h0000_0000;
      meas_res   = 32'h0000_0000;
      meas_valid = 1'b1;
      stop_delay = 8'h00;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      // Reset values and an unmapped address
      rd_chk("ctrl_rst", `IJS_CTRL_OFS, 32'h0000_0018);
      rd_chk("status_rst", `IJS_STATUS_OFS, 32'h0000_0001);
      rd_chk("irq_en_rst", `IJS_IRQ_EN_OFS, 32'h0000_0000);
      apb(1'b0, 12'h100, 32'h0000_0000, rd, er);
      check("unmapped_err", er, 1'b1);
      check("unmapped_rd", rd, 32'h0000_0000);
      wr_reg(`IJS_UPPER_OFS, 32'h0000_03E8);
      wr_reg(`IJS_LOWER_OFS, 32'h0000_000A);
      wr_reg(`IJS_IRQ_EN_OFS, 32'h0000_0007);
      // Timed pass, held pass, upper and lower fails, then both limits exactly met
      run(32'h0000_0018, 32'h0000_0000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0002,
          32'h0000_01F4, 3'b001, 8, 8'h00);
      run(32'h0000_001C, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002, 32'h0000_0001,
          32'h0000_01F4, 3'b001, 4, 8'h1E);
      run(32'h0000_0018, 32'h0000_0004, 32'h0000_0000, 32'h0000_0014, 32'h0000_0002,
          32'h0000_07D0, 3'b010, 12, 8'h00);
      run(32'h0000_0018, 32'h0000_0000, 32'h0000_0004, 32'h0000_0014, 32'h0000_0002,
          32'h0000_0005, 3'b100, 12, 8'h14);
      run(32'h0000_0018, 32'h0000_0000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0002,
          32'h0000_03E8, 3'b001, 8, 8'h00);
      run(32'h0000_0018, 32'h0000_0000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0002,
          32'h0000_000A, 3'b001, 8, 8'h00);
      // Upper check switched off, then an unvalidated low sample: both must pass
      run(32'h0000_0010, 32'h0000_0000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0002,
          32'h0000_07D0, 3'b001, 8, 8'h00);
      meas_valid <= 1'b0;
      run(32'h0000_0018, 32'h0000_0000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0002,
          32'h0000_0005, 3'b001, 8, 8'h00);
      meas_valid <= 1'b1;
      summarize();
   end
endmodule : ijs_top_test

`default_nettype wire
